/* adc_out_ctrl.sv */
// fifo and top level of the dual converter output control block
`timescale 1ns/1ps
`include "adc_out_params.svh"

module sample_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;
  wire [PW-1:0]     wr_inc = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
  wire [PW-1:0]     rd_inc = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
  wire [PW:0]       count_next = (push && !pop) ? count_reg + 1'b1 : ((pop && !push) ? count_reg - 1'b1 : count_reg);
  assign in_ready_o  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_i)
  begin
    if (ce_i && push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (ce_i)
    begin
      wr_ptr_reg <= push ? wr_inc : wr_ptr_reg;
      rd_ptr_reg <= pop ? rd_inc : rd_ptr_reg;
      count_reg  <= count_next;
    end
  end
endmodule

// Overview of operation
// RULE1: sample clock below 2 MSPS powers down; resumes automatically above it.
// RULE2: clock loop on after reset; then rates under 20 MSPS are not run.
// RULE3: writing loop-off bit lets rates down to 2 MSPS run; duty near half.
// RULE4: two channels, each a 10-bit word, bit 9 most significant.
// RULE5: each channel has its own valid strobe and over-range output.
// RULE6: coding select low gives offset binary, high gives two's complement.
// RULE7: two's complement word is offset binary word with top bit inverted.
// RULE8: offset binary: all ones, one then zeros, all zeros at scale points.
// RULE9: two's complement: 0111111111, all zeros, 1000000000 at scale points.
// RULE10: per-channel active-low enable; high floats that channel's outputs.
// RULE11: capture side keeps output enables static, never fast-multiplexed.
// RULE12: over-range detected separately for each channel.
// RULE13: over-range low while in range, high when input exceeds full scale.
// RULE14: over-range flag travels with its data word, six sample cycles latency.
// RULE15: select low disables the programming port; writes are ignored.
// RULE16: select low resets every programming register to zero.
// RULE17: capture side pulses select low once after power-up.
// RULE18: clock stopped over 250 ns or below 2 MHz: partial power-down, 100 us recovery.
// RULE19: with port enabled, each channel can be powered down by register.
// RULE20: valid strobe toggles once per delivered sample.
// RULE21: no valid strobe while powered down for a slow or stopped clock.
module adc_out_ctrl
  import adc_out_pkg::*;
#(
  parameter int PIPE_DEPTH = `PIPE_DEPTH,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               ce_i,
  input  wire logic               sample_clock_i,
  input  wire logic [`WORD_W-1:0] core_word_a_i,
  input  wire logic               core_over_a_i,
  input  wire logic [`WORD_W-1:0] core_word_b_i,
  input  wire logic               core_over_b_i,
  input  wire logic               coding_select_i,
  input  wire logic               out_en_b_a_i,
  input  wire logic               out_en_b_b_i,
  input  wire logic               select_i,
  input  wire logic               cfg_wr_i,
  input  wire logic [`CFG_W-1:0]  cfg_data_i,
  input  wire logic               capture_ready_i,
  output logic      [`WORD_W-1:0] data_a_o,
  output logic      [`WORD_W-1:0] data_b_o,
  output logic                    over_range_chan_a_o,
  output logic                    over_range_chan_b_o,
  output logic                    valid_strobe_chan_a_o,
  output logic                    valid_strobe_chan_b_o,
  output logic                    drive_en_b_a_o,
  output logic                    drive_en_b_b_o,
  output logic                    power_down_o,
  output logic                    loop_enabled_o,
  output logic [`CFG_W-1:0]       cfg_o,
  output logic                    overrun_o
);
  localparam logic [12:0] STOP_CYC    = 13'(`STOP_CYC);
  localparam logic [12:0] LOOP_CYC    = 13'(`LOOP_MAX_CYC);
  localparam logic [12:0] RECOVER_CYC = 13'(`RECOVER_CYC);

  // pin synchronisers: sample clock, coding, enable a, enable b, select
  logic [4:0]  sync1_reg;
  logic [4:0]  sync2_reg;
  logic        clk_prev_reg;
  logic [12:0] gap_reg;
  logic [12:0] per_cnt_reg;
  logic [12:0] period_reg;
  logic [12:0] rec_reg;
  run_state_t  state_reg;
  run_state_t  state_next;
  logic [`CFG_W-1:0] cfg_reg;
  chan_pair_t  pipe_reg [PIPE_DEPTH];
  logic [PIPE_DEPTH-1:0] pvld_reg;

  wire clk_s     = sync2_reg[4];
  wire coding_s  = sync2_reg[3];
  wire oe_b_a_s  = sync2_reg[2];
  wire oe_b_b_s  = sync2_reg[1];
  wire sel_s     = sync2_reg[0];
  wire rise      = clk_s && !clk_prev_reg;
  wire edge_any  = clk_s != clk_prev_reg;
  wire loop_on   = !cfg_reg[`CFG_LOOP_OFF];
  wire pd_a      = cfg_reg[`CFG_PD_A];
  wire pd_b      = cfg_reg[`CFG_PD_B];

  // RULE18: clock stopped watch
  wire stopped   = gap_reg > STOP_CYC;
  // RULE2: loop rejects slow clock
  wire loop_slow = loop_on && (period_reg > LOOP_CYC);
  wire too_slow  = stopped || loop_slow;
  wire running   = state_reg == ST_RUN;

  // RULE12: per-channel over-range capture
  chan_pair_t core_s;
  assign core_s.a = '{over: core_over_a_i, word: core_word_a_i};
  assign core_s.b = '{over: core_over_b_i, word: core_word_b_i};

  wire        fifo_in_ready;
  wire        fifo_out_valid;
  chan_pair_t fifo_out;
  // RULE14: word and flag leave the pipe together
  wire        push   = rise && running && pvld_reg[PIPE_DEPTH-1];
  wire        pop    = fifo_out_valid && capture_ready_i && running;

  // RULE8: offset binary passes through
  // RULE9: two's complement scale points
  // RULE7: top bit inverted in two's complement
  // RULE6: coding select picks format
  wire [`WORD_W-1:0] fmt_a = {fifo_out.a.word[9] ^ coding_s, fifo_out.a.word[8:0]};
  wire [`WORD_W-1:0] fmt_b = {fifo_out.b.word[9] ^ coding_s, fifo_out.b.word[8:0]};

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sync1_reg    <= 5'h06;
      sync2_reg    <= 5'h06;
      clk_prev_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_reg    <= {sample_clock_i, coding_select_i, out_en_b_a_i, out_en_b_b_i, select_i};
      sync2_reg    <= sync1_reg;
      clk_prev_reg <= clk_s;
    end
  end

  // RULE1: edge gap and period measurement
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      gap_reg     <= 13'h1FFF;
      per_cnt_reg <= 13'h0000;
      period_reg  <= 13'h1FFF;
    end
    else if (ce_i)
    begin
      gap_reg <= edge_any ? 13'h0001 : ((gap_reg == 13'h1FFF) ? gap_reg : gap_reg + 13'h0001);
      period_reg  <= rise ? per_cnt_reg : period_reg;
      per_cnt_reg <= rise ? 13'h0001 : ((per_cnt_reg == 13'h1FFF) ? per_cnt_reg : per_cnt_reg + 13'h0001);
    end
  end

  // RULE21: halt and recovery sequencing
  always_comb
  begin
    case (state_reg)
      ST_HALTED:  state_next = (rise && !too_slow) ? ST_RECOVER : ST_HALTED;
      ST_RECOVER: state_next = too_slow ? ST_HALTED : ((rec_reg >= RECOVER_CYC) ? ST_RUN : ST_RECOVER);
      ST_RUN:     state_next = too_slow ? ST_HALTED : ST_RUN;
      default:    state_next = ST_HALTED;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= ST_HALTED;
      rec_reg   <= 13'h0000;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      // RULE18: recovery wait count
      rec_reg   <= (state_reg == ST_RECOVER) ? rec_reg + 13'h0001 : 13'h0000;
    end
  end

  // RULE15: writes only with select high
  // RULE16: select low clears registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cfg_reg <= `CFG_RESET;
    end
    else if (ce_i)
    begin
      cfg_reg <= !sel_s ? `CFG_RESET : (cfg_wr_i ? cfg_data_i : cfg_reg);
    end
  end

  // RULE14: six-stage sample pipeline
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || (ce_i && !running))
    begin
      pvld_reg <= '0;
    end
    else if (ce_i && rise)
    begin
      pvld_reg <= {pvld_reg[PIPE_DEPTH-2:0], 1'b1};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i && rise)
    begin
      pipe_reg[0] <= core_s;
      for (int i = 1; i < PIPE_DEPTH; i++)
      begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  sample_fifo #(
    .WIDTH ($bits(chan_pair_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pipe_reg[PIPE_DEPTH-1]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out)
  );

  // RULE4: registered 10-bit words per channel
  // RULE5: separate strobe and flag
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      data_a_o              <= 10'h000;
      data_b_o              <= 10'h000;
      over_range_chan_a_o   <= 1'b0;
      over_range_chan_b_o   <= 1'b0;
      valid_strobe_chan_a_o <= 1'b0;
      valid_strobe_chan_b_o <= 1'b0;
      overrun_o             <= 1'b0;
    end
    else if (ce_i)
    begin
      overrun_o <= push && !fifo_in_ready;
      // RULE19: powered-down channel holds still
      // RULE20: one toggle per delivered word
      if (pop && !pd_a)
      begin
        data_a_o              <= fmt_a;
        // RULE13: flag high only past full scale
        over_range_chan_a_o   <= fifo_out.a.over;
        valid_strobe_chan_a_o <= !valid_strobe_chan_a_o;
      end
      if (pop && !pd_b)
      begin
        data_b_o              <= fmt_b;
        over_range_chan_b_o   <= fifo_out.b.over;
        valid_strobe_chan_b_o <= !valid_strobe_chan_b_o;
      end
    end
  end

  // RULE10: active-low output drive enables
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      drive_en_b_a_o <= 1'b1;
      drive_en_b_b_o <= 1'b1;
      power_down_o   <= 1'b1;
      loop_enabled_o <= 1'b1;
      cfg_o          <= `CFG_RESET;
    end
    else if (ce_i)
    begin
      drive_en_b_a_o <= oe_b_a_s;
      drive_en_b_b_o <= oe_b_b_s;
      power_down_o   <= state_next != ST_RUN;
      // RULE3: loop-off bit from register
      loop_enabled_o <= loop_on;
      cfg_o          <= cfg_reg;
    end
  end
endmodule

/* adc_out_monitor.sv */
// assertion checker for the dual converter output control block
`timescale 1ns/1ps
`include "adc_out_params.svh"
module adc_out_monitor (
  input wire logic               clk_i,
  input wire logic               rst_b_i,
  input wire logic               sample_clock_i,
  input wire logic               select_i,
  input wire logic               cfg_wr_i,
  input wire logic [`CFG_W-1:0]  cfg_data_i,
  input wire logic [`CFG_W-1:0]  cfg_o,
  input wire logic               loop_enabled_o,
  input wire logic               power_down_o,
  input wire logic               valid_strobe_chan_a_o,
  input wire logic               over_range_chan_a_o,
  input wire logic [`WORD_W-1:0] data_a_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic        clk_q;
  logic [4:0]  stop_cnt;
  logic [4:0]  loop_cnt;
  logic [12:0] pd_cnt;
  always_ff @(posedge clk_i)
  begin
    clk_q    <= sample_clock_i;
    stop_cnt <= (!rst_b_i || clk_q != sample_clock_i) ? 5'h00 : stop_cnt + 5'(stop_cnt != 5'h1F);
    loop_cnt <= (!rst_b_i || !loop_enabled_o) ? 5'h00 : loop_cnt + 5'(loop_cnt != 5'h1F);
    pd_cnt   <= (!rst_b_i || !power_down_o) ? 13'h0000 : pd_cnt + 13'(pd_cnt != 13'h1FFF);
  end
  sequence s_cfg_wr;
    select_i [*4] ##0 cfg_wr_i;
  endsequence
  sequence s_cfg_hold;
    (select_i && !cfg_wr_i) [*2];
  endsequence
  a_cfg_write: assert property (s_cfg_wr ##1 s_cfg_hold |-> cfg_o == $past(cfg_data_i, 2))
    else $error("config write not applied");
  a_sel_clear: assert property ((!select_i) [*6] |-> cfg_o == 3'h0)
    else $error("config not cleared by select");
  a_loop_cfg: assert property (loop_enabled_o == !cfg_o[`CFG_LOOP_OFF])
    else $error("loop state disagrees with config");
  a_stop_halts: assert property (stop_cnt >= 5'h14 |-> power_down_o)
    else $error("stopped clock did not power down");
  a_loop_slow: assert property (loop_cnt >= 5'h14 |-> power_down_o)
    else $error("slow clock ran with loop on");
  a_recover_time: assert property ($fell(power_down_o) |-> pd_cnt >= 13'h0FA0)
    else $error("recovery shorter than expected");
  a_pd_quiet: assert property (power_down_o && $past(power_down_o) && $past(power_down_o, 2)
    |-> $stable(valid_strobe_chan_a_o))
    else $error("strobe moved while powered down");
  a_chan_off: assert property (cfg_o[`CFG_PD_A] && $past(cfg_o[`CFG_PD_A])
    |-> $stable(valid_strobe_chan_a_o))
    else $error("strobe moved on powered down channel");
  a_over_pair: assert property ($changed(over_range_chan_a_o) || $changed(data_a_o)
    |-> $changed(valid_strobe_chan_a_o))
    else $error("flag or word changed without strobe");
endmodule

/* adc_out_params.svh */
// constants for the dual converter output control block
`ifndef ADC_OUT_PARAMS_SVH
`define ADC_OUT_PARAMS_SVH

`define CLK_PERIOD_NS   25
`define STOP_TIME_NS    250
`define LOOP_MIN_PER_NS 50
`define RECOVER_TIME_NS 100000
`define STOP_CYC        ((`STOP_TIME_NS) / (`CLK_PERIOD_NS))
`define LOOP_MAX_CYC    ((`LOOP_MIN_PER_NS) / (`CLK_PERIOD_NS))
`define RECOVER_CYC     (((`RECOVER_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

`define WORD_W          10
`define PIPE_DEPTH      6
`define FIFO_DEPTH      4

`define CFG_W           3
`define CFG_RESET       3'h0
`define CFG_LOOP_OFF    0
`define CFG_PD_A        1
`define CFG_PD_B        2

`endif

/* adc_out_pkg.sv */
// types shared by the dual converter output control block
package adc_out_pkg;

  typedef struct packed {
    logic       over;
    logic [9:0] word;
  } sample_t;

  typedef struct packed {
    sample_t a;
    sample_t b;
  } chan_pair_t;

  typedef enum logic [1:0] {
    ST_HALTED,
    ST_RECOVER,
    ST_RUN
  } run_state_t;

endpackage

/* capture_model.sv */
// capture side model that takes a word on each valid strobe toggle
`timescale 1ns/1ps
module capture_model
  import adc_out_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    stall_i,
  input  wire logic    slow_i,
  input  wire logic    strobe_a_i,
  input  wire logic    strobe_b_i,
  input  wire sample_t a_i,
  input  wire sample_t b_i,
  output logic         ready_o,
  output sample_t      last_a_o,
  output sample_t      last_b_o,
  output int           count_a_o,
  output int           count_b_o
);
  logic pace = 1'b0;
  logic sa_q = 1'b0;
  logic sb_q = 1'b0;
  initial
  begin
    count_a_o = 0;
    count_b_o = 0;
  end
  assign ready_o = !stall_i && (!slow_i || pace);
  always @(posedge clk_i)
  begin
    pace      <= ~pace;
    sa_q      <= strobe_a_i;
    sb_q      <= strobe_b_i;
    count_a_o <= count_a_o + int'(sa_q !== strobe_a_i);
    count_b_o <= count_b_o + int'(sb_q !== strobe_b_i);
    if (sa_q !== strobe_a_i) last_a_o <= a_i;
    if (sb_q !== strobe_b_i) last_b_o <= b_i;
  end
endmodule

/* tb.sv */
// self-checking bench for the dual converter output control block
`timescale 1ns/1ps
`include "adc_out_params.svh"
`define CHK(a, e) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      mismatches++; \
      $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); \
    end \
  end
module tb;
  import adc_out_pkg::*;
  typedef struct packed {
    logic       cs;
    logic       oe;
    sample_t    in_a;
    sample_t    in_b;
    logic [9:0] exp_a;
    logic [9:0] exp_b;
  } row_t;
  row_t rows [5] = '{
    '{1'h0, 1'h0, {1'h1, 10'h3FF}, {1'h0, 10'h000}, 10'h3FF, 10'h000},
    '{1'h0, 1'h1, {1'h0, 10'h200}, {1'h0, 10'h300}, 10'h200, 10'h300},
    '{1'h1, 1'h0, {1'h1, 10'h3FF}, {1'h0, 10'h000}, 10'h1FF, 10'h200},
    '{1'h1, 1'h1, {1'h0, 10'h200}, {1'h0, 10'h100}, 10'h000, 10'h300},
    '{1'h0, 1'h0, {1'h0, 10'h100}, {1'h1, 10'h300}, 10'h100, 10'h300}};
  logic       clk_i   = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       ph      = 1'b0;
  logic       sclk    = 1'b0;
  logic       run_clk = 1'b0;
  logic       cs      = 1'b0;
  logic       oe      = 1'b0;
  logic       sel     = 1'b0;
  logic       wr      = 1'b0;
  logic       stall   = 1'b0;
  logic       slow    = 1'b0;
  logic [2:0] cfg_d   = 3'h0;
  sample_t    in_a    = 11'h000;
  sample_t    in_b    = 11'h000;
  logic [9:0] data_a, data_b;
  logic       over_a, over_b, strobe_a, strobe_b, den_a, den_b;
  logic       power_down_o, loop_enabled_o, overrun_o, ready;
  logic [2:0] cfg_o;
  sample_t    last_a, last_b;
  int         cnt_a, cnt_b;
  int         mismatches = 0;
  int         checks = 0;
  always #(`CLK_PERIOD_NS / 2.0) clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    ph <= ~ph;
    if (run_clk && ph) sclk <= ~sclk;
  end
  adc_out_ctrl adc_out_ctrl_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .sample_clock_i(sclk),
    .core_word_a_i(in_a.word), .core_over_a_i(in_a.over), .core_word_b_i(in_b.word),
    .core_over_b_i(in_b.over), .coding_select_i(cs), .out_en_b_a_i(oe), .out_en_b_b_i(!oe),
    .select_i(sel), .cfg_wr_i(wr), .cfg_data_i(cfg_d), .capture_ready_i(ready),
    .data_a_o(data_a), .data_b_o(data_b), .over_range_chan_a_o(over_a), .over_range_chan_b_o(over_b),
    .valid_strobe_chan_a_o(strobe_a), .valid_strobe_chan_b_o(strobe_b), .drive_en_b_a_o(den_a),
    .drive_en_b_b_o(den_b), .power_down_o(power_down_o), .loop_enabled_o(loop_enabled_o),
    .cfg_o(cfg_o), .overrun_o(overrun_o));
  capture_model capture_model_inst (
    .clk_i(clk_i), .stall_i(stall), .slow_i(slow), .strobe_a_i(strobe_a), .strobe_b_i(strobe_b),
    .a_i({over_a, data_a}), .b_i({over_b, data_b}), .ready_o(ready), .last_a_o(last_a),
    .last_b_o(last_b), .count_a_o(cnt_a), .count_b_o(cnt_b));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic cfg_write(input logic [2:0] d);
    cyc(1);
    wr    <= 1'b1;
    cfg_d <= d;
    cyc(1);
    wr    <= 1'b0;
    cyc(4);
    @(negedge clk_i);
  endtask
  task automatic wait_fall(output int k);
    k = 0;
    while (power_down_o !== 1'b0 && k < 4500)
    begin
      @(negedge clk_i);
      k++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #(`CLK_PERIOD_NS * 20000);
    mismatches++;
    complete_run();
  end
  initial
  begin
    int k;
    int na;
    int nb;
    cyc(16);
    @(negedge clk_i);
    `CHK({cfg_o, loop_enabled_o, power_down_o, den_a}, 6'h07)
    cyc(1);
    rst_b_i <= 1'b1;
    run_clk <= 1'b1;
    cfg_write(3'h1);
    `CHK(cfg_o, 3'h0)
    cyc(1);
    sel <= 1'b1;
    cyc(200);
    @(negedge clk_i);
    `CHK(power_down_o, 1'b1)
    cfg_write(3'h1);
    `CHK({cfg_o, loop_enabled_o}, 4'h2)
    wait_fall(k);
    `CHK(k inside {[3990:4100]}, 1'b1)
    na = cnt_a;
    foreach (rows[i])
    begin
      cyc(1);
      cs   <= rows[i].cs;
      oe   <= rows[i].oe;
      in_a <= rows[i].in_a;
      in_b <= rows[i].in_b;
      cyc(80);
      @(negedge clk_i);
      `CHK(last_a, {rows[i].in_a.over, rows[i].exp_a})
      `CHK(last_b, {rows[i].in_b.over, rows[i].exp_b})
      `CHK({den_a, den_b}, {rows[i].oe, !rows[i].oe})
    end
    `CHK((cnt_a - na) inside {[93:97]}, 1'b1)
    cyc(1);
    stall <= 1'b1;
    k = 0;
    while (overrun_o !== 1'b1 && k < 200)
    begin
      @(negedge clk_i);
      k++;
    end
    `CHK(overrun_o, 1'b1)
    cyc(1);
    stall <= 1'b0;
    slow  <= 1'b1;
    cyc(100);
    @(negedge clk_i);
    `CHK({last_a, last_b}, {11'h100, 11'h700})
    cfg_write(3'h3);
    na = cnt_a;
    nb = cnt_b;
    cyc(40);
    @(negedge clk_i);
    `CHK({cnt_a == na, cnt_b > nb}, 2'h3)
    cyc(1);
    run_clk <= 1'b0;
    cyc(30);
    @(negedge clk_i);
    `CHK(power_down_o, 1'b1)
    nb = cnt_b;
    cyc(40);
    @(negedge clk_i);
    `CHK(cnt_b == nb, 1'b1)
    cyc(1);
    run_clk <= 1'b1;
    wait_fall(k);
    `CHK(k inside {[4000:4100]}, 1'b1)
    cyc(1);
    sel <= 1'b0;
    cyc(30);
    @(negedge clk_i);
    `CHK({cfg_o, loop_enabled_o, power_down_o}, 5'h03)
    complete_run();
  end
endmodule
bind adc_out_ctrl adc_out_monitor adc_out_monitor_inst (.*);
